// [sirq_pkg.sv]
/*
 * Shared constants and types for the serial interrupt link: register map,
 * field positions, slot layout, frame widths and sequencer state types.
 * Assumes a single clock domain shared by both link ends and the bus.
 */
`default_nettype none

package sirq_pkg;

    // ================================================================
    // Register map (byte addresses, one aligned word each)
    // ================================================================
    localparam logic [11:0] REG_CTRL_OFS   = 12'h064;
    localparam logic [11:0] REG_STATUS_OFS = 12'h068;
    localparam logic [11:0] REG_LEVELS_OFS = 12'h06C;

    localparam int          CTRL_WIDTH_LSB = 0;
    localparam int          CTRL_STOP3_BIT = 2;
    localparam int          CTRL_EN_BIT    = 7;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    localparam int          STAT_MGMT_BIT  = 0;
    localparam int          STAT_QUIET_BIT = 1;
    localparam int          STAT_BUSY_BIT  = 2;

    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HRESP_OKAY     = 2'h0;

    // ================================================================
    // Slot layout
    // ================================================================
    localparam int          SLOT_COUNT     = 21;
    localparam logic [4:0]  SLOT_LAST      = 5'h15;
    localparam int          SLOT_MGMT      = 2;
    localparam int          SLOT_IO_CHECK_REQUEST     = 16;
    localparam int          SLOT_PCI_A     = 17;
    localparam logic [4:0]  SLOT_MGMT_NUM  = 5'h03;
    // Idle line is high; ISA slots reset low (not requested)
    localparam logic [20:0] SAMPLE_RESET   = 21'h1F_0004;
    // ISA outputs never fed from the stream: IRQ0, slot 2, IRQ8, IRQ13
    localparam logic [15:0] ISA_PASS_MASK  = 16'hDEFA;

    // ================================================================
    // Frame widths in clocks
    // ================================================================
    localparam logic [3:0]  START_LOW_4    = 4'h4;
    localparam logic [3:0]  START_LOW_6    = 4'h6;
    localparam logic [3:0]  START_LOW_8    = 4'h8;
    localparam logic [3:0]  STOP_LOW_QUIET = 4'h2;
    localparam logic [3:0]  STOP_LOW_CONT  = 4'h3;
    localparam logic [3:0]  LOWRUN_MAX     = 4'hF;
    localparam logic [1:0]  QUIET_GAP_MIN  = 2'h3;

    typedef enum logic [2:0] {
        SEQ_OFF, SEQ_GAP, SEQ_IDLE, SEQ_START, SEQ_DATA, SEQ_STOP, SEQ_STOP_HIGH
    } sirq_seq_type;

    typedef enum logic [1:0] {
        PH_SAMPLE, PH_RECOVER, PH_TURN
    } sirq_phase_type;

    typedef enum logic {
        PER_WAIT, PER_COUNT
    } sirq_per_type;

    function automatic logic [3:0] sirq_start_low(input logic [1:0] code);
        case (code)
            2'h0:    sirq_start_low = START_LOW_4;
            2'h1:    sirq_start_low = START_LOW_6;
            default: sirq_start_low = START_LOW_8;
        endcase
    endfunction

endpackage

`default_nettype wire

// [sirq_if.sv]
/*
 * The shared open-drain interrupt line between controller and peripheral.
 * Resolves the wire level from both ends' enables; external pull-up assumed.
 */
`timescale 1ns/1ps
`default_nettype none

interface sirq_if;
    logic ctrl_o;
    logic ctrl_oe;
    logic per_o;
    logic per_oe;
    logic line;

    // Pull-up wins unless someone drives low
    assign line = ~((ctrl_oe & ~ctrl_o) | (per_oe & ~per_o));

    modport controller (input line, output ctrl_o, output ctrl_oe);
    modport peripheral (input line, output per_o, output per_oe);
endinterface // sirq_if

`default_nettype wire

// [sirq_regs.sv]
/*
 * AHB-Lite slave holding the controller's registers: control, status with
 * a sticky management flag, and the sampled slot levels.
 * Assumes a single master, whole-word transfers, zero-wait-state answers.
 */
`timescale 1ns/1ps
`default_nettype none

module sirq_regs
    import sirq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    input  wire logic        set_mgmt,
    input  wire logic        quiet,
    input  wire logic        busy,
    input  wire logic [20:0] levels,
    output logic      [7:0]  ctrl
);

    // ================================================================
    // Address phase capture
    // ================================================================
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic        mgmt_flag;
    logic [7:0]  next_ctrl;
    logic        next_flag;
    logic        addr_ok;

    assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == 3'h2);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[11:0];
        end
    end

    // ================================================================
    // Register updates
    // ================================================================
    always_comb begin
        next_ctrl = ctrl;
        next_flag = mgmt_flag;
        if (wr_pend && wr_addr == REG_CTRL_OFS) begin
            next_ctrl = hwdata[7:0];
        end
        if (wr_pend && wr_addr == REG_STATUS_OFS && hwdata[STAT_MGMT_BIT]) begin
            next_flag = 1'b0;
        end
        // A new event in the clearing cycle survives
        if (set_mgmt) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl      <= CTRL_RESET;
            mgmt_flag <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            mgmt_flag <= next_flag;
        end
    end

    // ================================================================
    // Read data, bypassing a write that lands on the same edge
    // ================================================================
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[11:0])
                REG_CTRL_OFS:   hrdata <= {24'h00_0000, next_ctrl};
                REG_STATUS_OFS: hrdata <= {29'h0000_0000, busy, quiet, next_flag};
                REG_LEVELS_OFS: hrdata <= {11'h000, levels};
                default:        hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

endmodule // sirq_regs

`default_nettype wire

// [sirq_controller.sv]
/*
 * Controller end of the serial interrupt link: frame sequencer, slot
 * sampler and decoder, with registers reached over AHB-Lite.
 * Assumes the line has an external pull-up and that peripherals count
 * frames from the rising edge that closes each start frame.
 */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sirq_controller
    import sirq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    sirq_if.controller       link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    input  wire logic        pci_int_line_a,
    input  wire logic        pci_int_line_b,
    input  wire logic        pci_int_line_c,
    input  wire logic        pci_int_line_d,
    input  wire logic        legacy_io_check_input_n,
    input  wire logic [1:0]  internal_disk_irq,
    output logic      [15:0] isa_irq,
    output logic      [3:0]  pci_int_out_n,
    output logic             system_mgmt_request,
    output logic             io_check_request,
    output logic      [1:0]  bus_master_disk_logic
);

    // ================================================================
    // Declarations
    // ================================================================
    sirq_seq_type   state;
    sirq_seq_type   next_state;
    sirq_phase_type phase;
    sirq_phase_type next_phase;
    logic [4:0]     slot;
    logic [4:0]     next_slot;
    logic [3:0]     cnt;
    logic [3:0]     next_cnt;
    logic           quiet;
    logic           next_quiet;
    logic           next_drive_low;
    logic           next_drive_high;
    logic [7:0]     ctrl;
    logic           enable;
    logic [3:0]     start_low;
    logic [3:0]     stop_low;
    logic [20:0]    sampled;
    logic           in_sample;
    logic           set_mgmt;
    logic           busy;

    assign enable    = ctrl[CTRL_EN_BIT];
    assign start_low = sirq_start_low(ctrl[CTRL_WIDTH_LSB+1:CTRL_WIDTH_LSB]);
    assign stop_low  = ctrl[CTRL_STOP3_BIT] ? STOP_LOW_CONT : STOP_LOW_QUIET;
    assign in_sample = (state == SEQ_DATA) && (phase == PH_SAMPLE);
    assign set_mgmt  = in_sample && (slot == SLOT_MGMT_NUM) && !link.line;
    assign busy      = (state != SEQ_OFF) && (state != SEQ_GAP) && (state != SEQ_IDLE);

    // ================================================================
    // Register slave
    // ================================================================
    sirq_regs u_regs (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .set_mgmt  (set_mgmt),
        .quiet     (quiet),
        .busy      (busy),
        .levels    (sampled),
        .ctrl      (ctrl)
    );

    // ================================================================
    // Frame sequencer
    // ================================================================
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_slot  = slot;
        next_cnt   = cnt;
        next_quiet = quiet;
        case (state)
            SEQ_OFF: begin
                next_quiet = 1'b0;
                if (enable) begin
                    next_state = SEQ_GAP;
                end
            end
            SEQ_GAP: begin
                // At least one released clock before any new start
                if (!enable) begin
                    next_state = SEQ_OFF;
                end else if (quiet) begin
                    next_state = SEQ_IDLE;
                end else begin
                    next_state = SEQ_START;
                    next_cnt   = start_low;
                end
            end
            SEQ_IDLE: begin
                if (!enable) begin
                    next_state = SEQ_OFF;
                end else if (!link.line) begin
                    next_state = SEQ_START;
                    next_cnt   = start_low - 4'h1;
                end
            end
            SEQ_START: begin
                if (cnt == 4'h1) begin
                    next_state = SEQ_DATA;
                    next_phase = PH_RECOVER;
                    next_slot  = 5'h00;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            SEQ_DATA: begin
                case (phase)
                    PH_SAMPLE:  next_phase = PH_RECOVER;
                    PH_RECOVER: next_phase = PH_TURN;
                    PH_TURN: begin
                        if (slot == SLOT_LAST) begin
                            next_state = SEQ_STOP;
                            next_cnt   = stop_low;
                        end else begin
                            next_phase = PH_SAMPLE;
                            next_slot  = slot + 5'h01;
                        end
                    end
                    default: next_phase = PH_TURN;
                endcase
            end
            SEQ_STOP: begin
                if (cnt == 4'h1) begin
                    next_state = SEQ_STOP_HIGH;
                    next_quiet = !ctrl[CTRL_STOP3_BIT];
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            SEQ_STOP_HIGH: next_state = SEQ_GAP;
            default:       next_state = SEQ_OFF;
        endcase
    end

    always_comb begin
        next_drive_low  = (next_state == SEQ_START) || (next_state == SEQ_STOP);
        // High clock after every low stretch the controller made
        next_drive_high = (next_state == SEQ_STOP_HIGH) ||
                          ((next_state == SEQ_DATA) && (next_phase == PH_RECOVER) &&
                           (next_slot == 5'h00));
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= SEQ_OFF;
            phase <= PH_TURN;
            slot  <= 5'h00;
            cnt   <= 4'h0;
            quiet <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            slot  <= next_slot;
            cnt   <= next_cnt;
            quiet <= next_quiet;
        end
    end

    // Released everywhere else, leaving the pull-up in charge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.ctrl_oe <= 1'b0;
            link.ctrl_o  <= 1'b1;
        end else begin
            link.ctrl_oe <= next_drive_low | next_drive_high;
            link.ctrl_o  <= !next_drive_low;
        end
    end

    // ================================================================
    // Slot sampling; twenty-one slots only, nothing beyond PCI D
    // ================================================================
    for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                sampled[g] <= SAMPLE_RESET[g];
            end else if (in_sample && slot == 5'(g + 1)) begin
                sampled[g] <= link.line;
            end
        end
    end

    // ================================================================
    // Decoded outputs
    // ================================================================
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            isa_irq               <= 16'h0000;
            pci_int_out_n         <= 4'hF;
            system_mgmt_request   <= 1'b0;
            io_check_request      <= 1'b0;
            bus_master_disk_logic <= 2'h0;
        end else begin
            // Internally generated sources are never overridden
            isa_irq               <= sampled[15:0] & ISA_PASS_MASK;
            pci_int_out_n         <= sampled[SLOT_PCI_A+3:SLOT_PCI_A] &
                                     {pci_int_line_d, pci_int_line_c,
                                      pci_int_line_b, pci_int_line_a};
            system_mgmt_request   <= !sampled[SLOT_MGMT];
            io_check_request      <= !sampled[SLOT_IO_CHECK_REQUEST] | !legacy_io_check_input_n;
            // Disk logic sees only its own controllers, not slots 14/15
            bus_master_disk_logic <= internal_disk_irq;
        end
    end

endmodule // sirq_controller

`default_nettype wire

// [sirq_peripheral.sv]
/*
 * Peripheral end of the serial interrupt link: follows frames on the
 * shared line and reports its enabled slots; requests starts in quiet mode.
 * Assumes the controller makes start frames of at least four low clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module sirq_peripheral
    import sirq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    sirq_if.peripheral       link,
    input  wire logic [20:0] slot_enable,
    input  wire logic [20:0] irq_level,
    output logic             quiet_mode,
    output logic             frame_active
);

    // ================================================================
    // Frame follower
    // ================================================================
    sirq_per_type   state;
    sirq_phase_type phase;
    logic [4:0]     slot;
    logic [3:0]     lowrun;
    logic [1:0]     highrun;
    logic           drove;
    logic [20:0]    sent;
    logic           pending;
    logic           request;

    assign pending = |((irq_level ^ sent) & slot_enable);
    assign request = (state == PER_WAIT) && quiet_mode && link.line &&
                     (highrun == QUIET_GAP_MIN) && pending && !link.per_oe;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= PER_WAIT;
            phase      <= PH_TURN;
            slot       <= 5'h00;
            lowrun     <= 4'h0;
            highrun    <= 2'h0;
            quiet_mode <= 1'b0;
        end else if (state == PER_WAIT) begin
            if (!link.line) begin
                highrun <= 2'h0;
                if (lowrun != LOWRUN_MAX) begin
                    lowrun <= lowrun + 4'h1;
                end
            end else begin
                lowrun <= 4'h0;
                if (highrun != QUIET_GAP_MIN) begin
                    highrun <= highrun + 2'h1;
                end
                // Long low is a start, short low a stop
                if (lowrun >= START_LOW_4) begin
                    state <= PER_COUNT;
                    phase <= PH_TURN;
                    slot  <= 5'h00;
                end else if (lowrun == STOP_LOW_QUIET) begin
                    quiet_mode <= 1'b1;
                end else if (lowrun == STOP_LOW_CONT) begin
                    quiet_mode <= 1'b0;
                end
            end
        end else begin
            highrun <= 2'h0;
            case (phase)
                PH_TURN: begin
                    if (slot == SLOT_LAST) begin
                        state <= PER_WAIT;
                    end else begin
                        phase <= PH_SAMPLE;
                        slot  <= slot + 5'h01;
                    end
                end
                PH_SAMPLE:  phase <= PH_RECOVER;
                PH_RECOVER: phase <= PH_TURN;
                default:    phase <= PH_TURN;
            endcase
        end
    end

    // ================================================================
    // Line drive, registered for the clock being entered
    // ================================================================
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.per_oe <= 1'b0;
            link.per_o  <= 1'b1;
            drove       <= 1'b0;
            sent        <= 21'h1F_FFFF;
        end else if (state == PER_COUNT && phase == PH_TURN && slot != SLOT_LAST) begin
            // Next clock is the sample phase of slot+1
            link.per_oe <= slot_enable[slot] & !irq_level[slot];
            link.per_o  <= 1'b0;
            drove       <= slot_enable[slot] & !irq_level[slot];
            if (slot_enable[slot]) begin
                sent[slot] <= irq_level[slot];
            end
        end else if (state == PER_COUNT && phase == PH_SAMPLE) begin
            link.per_oe <= drove;
            link.per_o  <= 1'b1;
        end else if (request) begin
            // One low clock; the controller holds it low from there
            link.per_oe <= 1'b1;
            link.per_o  <= 1'b0;
        end else begin
            link.per_oe <= 1'b0;
            link.per_o  <= 1'b1;
            drove       <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_active <= 1'b0;
        end else begin
            frame_active <= (state == PER_COUNT);
        end
    end

endmodule // sirq_peripheral

`default_nettype wire

// [sirq_monitor.sv]
/* Checker for the shared serial interrupt line.
   Takes the link interface signals as inputs; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module sirq_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ctrl_o,
    input wire logic ctrl_oe,
    input wire logic per_o,
    input wire logic per_oe,
    input wire logic line
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] lo_run;
    logic [6:0] pos;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) lo_run <= 4'h0;
        else lo_run <= line ? 4'h0 : lo_run + 4'h1;
    // Offset past the start frame; saturates so quiet idle never aliases a slot
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) pos <= 7'h7F;
        else pos <= (line && lo_run > 4'h3) ? 7'h01 : pos + {6'h0, pos != 7'h7F};
    sequence s_cl; ctrl_oe && !ctrl_o; endsequence
    property p_ch; s_cl |=> ctrl_oe; endproperty
    a_ch: assert property (p_ch) else $error("low released");
    property p_cr; ctrl_oe && ctrl_o |=> !ctrl_oe; endproperty
    a_cr: assert property (p_cr) else $error("high kept");
    property p_pr; per_oe && !per_o |=> (per_oe && per_o) || (ctrl_oe && !ctrl_o); endproperty
    a_pr: assert property (p_pr) else $error("no recovery");
    property p_pt; per_oe && per_o |=> !per_oe; endproperty
    a_pt: assert property (p_pt) else $error("no turnaround");
    property p_run; line && lo_run != 4'h0 |-> lo_run inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8}; endproperty
    a_run: assert property (p_run) else $error("bad low width");
    property p_qs; !line && !ctrl_oe && pos > 7'h40 |=> s_cl [*3]; endproperty
    a_qs: assert property (p_qs) else $error("quiet start dropped");
    property p_slot; per_oe && !per_o |-> (pos % 3 == 2 && pos < 7'h3F) || pos > 7'h40; endproperty
    a_slot: assert property (p_slot) else $error("slot timing");
    property p_stop; s_cl |-> pos > 7'h40; endproperty
    a_stop: assert property (p_stop) else $error("stop misplaced");
endmodule // sirq_monitor
`default_nettype wire

// [sirq_tb.sv]
/* Bench joining both link ends on one line; registers over AHB-Lite.
   Assumes a zero-wait slave and a 100 ns clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench
    import sirq_pkg::*;
;
    logic        clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, hrdy, mgmt, ioc, io_n = 1'b1, pq, fa;
    logic [1:0]  htrans = 2'h0, disk_in = 2'h1, disk;
    logic [3:0]  pins = 4'hF, pci_n;
    logic [15:0] isa;
    logic [20:0] lv = 21'h1F_FFFF;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int          n_mismatch = 0, n_checks = 0;
    sirq_if bus ();
    sirq_controller u_sirq_controller (.clk, .sys_rst, .link(bus.controller), .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hready(hrdy), .hwdata, .hrdata, .hreadyout(hrdy), .hresp(),
        .pci_int_line_a(pins[0]), .pci_int_line_b(pins[1]), .pci_int_line_c(pins[2]), .pci_int_line_d(pins[3]),
        .legacy_io_check_input_n(io_n), .internal_disk_irq(disk_in), .isa_irq(isa), .pci_int_out_n(pci_n),
        .system_mgmt_request(mgmt), .io_check_request(ioc), .bus_master_disk_logic(disk));
    sirq_peripheral u_sirq_peripheral (.clk, .sys_rst, .link(bus.peripheral), .slot_enable(21'h1F_FFFF),
        .irq_level(lv), .quiet_mode(pq), .frame_active(fa));
    sirq_monitor u_sirq_monitor (.clk, .sys_rst, .ctrl_o(bus.ctrl_o), .ctrl_oe(bus.ctrl_oe),
        .per_o(bus.per_o), .per_oe(bus.per_oe), .line(bus.line));
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic t_width();
        int n;
        xfer(1'b0, 12'h070, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, REG_CTRL_OFS, 32'h0);
            repeat (100) @(posedge clk);
            xfer(1'b1, REG_CTRL_OFS, 32'h0000_0084 | 32'(c));
            do @(negedge clk); while (bus.line !== 1'b0);
            for (n = 0; bus.line === 1'b0; n++) @(negedge clk);
            `CHK("start", (c == 3) ? 8 : 4 + 2 * c, n)
            repeat (2) @(negedge clk);
            `CHK("frame", 1'b1, fa)
            @(posedge clk);
        end
        $display("width done");
    endtask
    task automatic t_cont();
        lv   <= 21'h0E_A5F3;
        pins <= 4'hE;
        repeat (250) @(posedge clk);
        xfer(1'b0, REG_LEVELS_OFS, 32'h0);
        `CHK("levels", {11'h000, lv}, rd)
        @(negedge clk);
        `CHK("isa", lv[15:0] & ISA_PASS_MASK, isa)
        `CHK("pci", lv[20:17] & pins, pci_n)
        `CHK("mgmt", 1'b1, mgmt)
        `CHK("io_check_request", 1'b1, ioc)
        `CHK("disk", disk_in, disk)
        @(posedge clk);
        $display("cont done");
    endtask
    task automatic t_quiet();
        int n;
        xfer(1'b1, REG_CTRL_OFS, 32'h0000_0082);
        repeat (200) @(posedge clk);
        xfer(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK("quiet", 2'h3, rd[1:0])
        lv <= 21'h1F_FFFF;
        // Peripheral asks for a start; whole low stretch is the full width
        do @(negedge clk); while (bus.line !== 1'b0);
        for (n = 0; bus.line === 1'b0; n++) @(negedge clk);
        `CHK("qstart", 8, n)
        repeat (100) @(posedge clk);
        xfer(1'b0, REG_LEVELS_OFS, 32'h0);
        `CHK("levels", 32'h001F_FFFF, rd)
        `CHK("per quiet", 1'b1, pq)
        `CHK("frame idle", 1'b0, fa)
        `CHK("io_check_request off", 1'b0, ioc)
        io_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK("legacy io_check_request", 1'b1, ioc)
        @(posedge clk);
        io_n <= 1'b1;
        xfer(1'b1, REG_STATUS_OFS, 32'h0000_0001);
        xfer(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK("flag", 1'b0, rd[STAT_MGMT_BIT])
        // Re-enable must start continuous even though quiet was set
        xfer(1'b1, REG_CTRL_OFS, 32'h0);
        repeat (3) @(posedge clk);
        xfer(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK("quiet off", 1'b0, rd[STAT_QUIET_BIT])
        xfer(1'b1, REG_CTRL_OFS, 32'h0000_0082);
        do @(negedge clk); while (bus.line !== 1'b0);
        for (n = 0; bus.line === 1'b0; n++) @(negedge clk);
        `CHK("restart", 8, n)
        @(posedge clk);
        $display("quiet done");
    endtask
    task automatic wrap_up(input int late);
        n_mismatch += late;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial forever #50 clk = ~clk;
    // Whole run is near 1070 clocks
    initial #500_000 wrap_up(1);
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_width();
        t_cont();
        t_quiet();
        wrap_up(0);
    end
endmodule // testbench
`default_nettype wire
